//--- core/gpio_port_defs.vh
`ifndef GPIO_PORT_DEFS_VH
`define GPIO_PORT_DEFS_VH

// register byte addresses on the apb bus
`define ADDR_PORT_OUTPUT_CONTROL 12'h000
`define ADDR_PIN_LEVEL_REGISTER  12'h004
`define ADDR_CHIP_MODE_REGISTER  12'h008

// port_output_control fields
`define OUT_DATA_LSB 1
`define OUT_DATA_MSB 2
`define OUT_DIR_LSB  4
`define OUT_DIR_MSB  5

// chip_mode_register fields
`define MODE_REF_OUT_BIT 0
`define MODE_REF_IN_BIT  1

// reset values
`define RST_PORT_OUTPUT_CONTROL 8'h30
`define RST_CHIP_MODE_REGISTER  8'h00

`endif

//--- core/sensor_drive_gpio_port.v
`timescale 1ns/1ps
`default_nettype none
`include "gpio_port_defs.vh"

module sensor_drive_gpio_port (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output wire        pslverr,
    output reg  [31:0] prdata,
    input  wire        port_pin_zero_in,
    output wire        port_pin_zero_out,
    output wire        port_pin_zero_oe,
    input  wire        port_pin_one_in,
    output wire        port_pin_one_out,
    output wire        port_pin_one_oe,
    output wire        reference_monitor_out_select,
    output wire        external_reference_in_select
);

////////////////////////////////////////////////////////////////////////////////
reg  [7:0] port_output_control;
reg  [7:0] chip_mode_register;
reg  [1:0] sync1;
reg  [1:0] sync2;
reg  [1:0] sync3;
reg  [1:0] pin_level_register;
wire       wr_en;
wire       rd_en;
wire       addr_ok;
wire [1:0] dir;
wire [1:0] dat;
wire [1:0] bypass;
wire [2:0] reg_hit;
reg  [7:0] next_port_output_control;
reg  [7:0] next_chip_mode_register;
reg  [31:0] next_prdata;
reg  [1:0] next_pin_level_register;

////////////////////////////////////////////////////////////////////////////////
// one-hot register select: bit 0 output control, bit 1 pin level, bit 2 mode.
// a full compare costs a few gates but keeps aliases of the words from answering
function [2:0] reg_select;
    input [11:0] addr;
    begin
        case (addr)
            `ADDR_PORT_OUTPUT_CONTROL: reg_select = 3'b001;
            `ADDR_PIN_LEVEL_REGISTER:  reg_select = 3'b010;
            `ADDR_CHIP_MODE_REGISTER:  reg_select = 3'b100;
            default:                   reg_select = 3'b000;
        endcase
    end
endfunction

// widen an 8-bit register to the bus word with zero upper bits
function [31:0] bus_word;
    input [7:0] value;
    begin
        bus_word = {24'h00_0000, value};
    end
endfunction

// pin zero can be handed to the reference monitor output, pin one to the
// external reference input; each select claims only its own pin
function [1:0] mode_bypass;
    input [7:0] mode;
    begin
        mode_bypass = {mode[`MODE_REF_IN_BIT], mode[`MODE_REF_OUT_BIT]};
    end
endfunction

// a pin drives only when its direction bit is set and the analog path
// has not claimed it
function pin_drive_enable;
    input dir_bit;
    input bypass_bit;
    begin
        pin_drive_enable = dir_bit & ~bypass_bit;
    end
endfunction

// the drive value is forced low while the driver is off, so a released
// pin never shows stale data on the output net
function pin_drive_value;
    input data_bit;
    input enable;
    begin
        pin_drive_value = data_bit & enable;
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// zero wait states: every access completes in its first access cycle
assign pready  = 1'b1;
assign reg_hit = reg_select(paddr);
assign wr_en   = psel & penable & pwrite;
assign rd_en   = psel & ~penable & ~pwrite;
assign addr_ok = |reg_hit;
// unmapped addresses answer with an error in the access phase
assign pslverr = psel & penable & ~addr_ok;

////////////////////////////////////////////////////////////////////////////////
// register writes; the input register has no write path at all
always @* begin
    next_port_output_control = port_output_control;
    next_chip_mode_register  = chip_mode_register;
    if (wr_en) begin
        if (reg_hit[0]) begin
            next_port_output_control = pwdata[7:0];
        end
        if (reg_hit[2]) begin
            next_chip_mode_register = pwdata[7:0];
        end
        // a write that hits the pin level register changes nothing
    end
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        port_output_control <= `RST_PORT_OUTPUT_CONTROL;
        chip_mode_register  <= `RST_CHIP_MODE_REGISTER;
    end else begin
        port_output_control <= next_port_output_control;
        chip_mode_register  <= next_chip_mode_register;
    end
end

////////////////////////////////////////////////////////////////////////////////
// read data registered during setup so it is stable for the access phase
always @* begin
    next_prdata = prdata;
    if (rd_en) begin
        case (reg_hit)
            3'b001:  next_prdata = bus_word(port_output_control);
            3'b010:  next_prdata = bus_word({6'h00, pin_level_register});
            3'b100:  next_prdata = bus_word(chip_mode_register);
            default: next_prdata = 32'h0000_0000;
        endcase
    end
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata <= 32'h0000_0000;
    end else begin
        prdata <= next_prdata;
    end
end

////////////////////////////////////////////////////////////////////////////////
// pins are asynchronous; a level counts once stages two and three agree.
// no filtering beyond this, so noisy inputs need an external filter.
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        sync1 <= 2'b00;
        sync2 <= 2'b00;
        sync3 <= 2'b00;
    end else begin
        sync1 <= {port_pin_one_in, port_pin_zero_in};
        sync2 <= sync1;
        sync3 <= sync2;
    end
end

// per pin: a level is taken only where the last two stages agree, so one
// pin settling never holds back the other
always @* begin
    next_pin_level_register = pin_level_register;
    if (sync2[0] == sync3[0]) begin
        next_pin_level_register[0] = sync3[0];
    end
    if (sync2[1] == sync3[1]) begin
        next_pin_level_register[1] = sync3[1];
    end
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pin_level_register <= 2'b00;
    end else begin
        pin_level_register <= next_pin_level_register;
    end
end

////////////////////////////////////////////////////////////////////////////////
// pin drive
assign dir    = port_output_control[`OUT_DIR_MSB:`OUT_DIR_LSB];
assign dat    = port_output_control[`OUT_DATA_MSB:`OUT_DATA_LSB];
assign bypass = mode_bypass(chip_mode_register);

// a bypassed pin belongs to the analog path, so the digital driver lets go
assign port_pin_zero_oe  = pin_drive_enable(dir[0], bypass[0]);
assign port_pin_one_oe   = pin_drive_enable(dir[1], bypass[1]);
assign port_pin_zero_out = pin_drive_value(dat[0], port_pin_zero_oe);
assign port_pin_one_out  = pin_drive_value(dat[1], port_pin_one_oe);

assign reference_monitor_out_select = bypass[0];
assign external_reference_in_select = bypass[1];

endmodule
`default_nettype wire

//--- tb/gpio_port_props.sv
`timescale 1ns/1ps
`default_nettype none
module gpio_port_props (
    input wire logic        pclk, presetn, psel, penable, pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        port_pin_zero_oe, port_pin_one_oe, port_pin_zero_out, port_pin_one_out,
    input wire logic        reference_monitor_out_select, external_reference_in_select
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire       rs = reference_monitor_out_select, ri = external_reference_in_select;
    wire [3:0] pv = {port_pin_one_oe, port_pin_zero_oe, port_pin_one_out, port_pin_zero_out};
    wire       wr = psel & penable & pwrite, w0 = wr & paddr == 12'h000;
    property p_oe0; w0 |=> pv[2] == ($past(pwdata[4]) & !rs); endproperty
    a_oe0: assert property (p_oe0) else $error("oe0");
    property p_oe1; w0 |=> pv[3] == ($past(pwdata[5]) & !ri); endproperty
    a_oe1: assert property (p_oe1) else $error("oe1");
    property p_d0; w0 |=> pv[0] == ($past(pwdata[1]) & pv[2]); endproperty
    a_d0: assert property (p_d0) else $error("d0");
    property p_d1; w0 |=> pv[1] == ($past(pwdata[2]) & pv[3]); endproperty
    a_d1: assert property (p_d1) else $error("d1");
    property p_rst; $rose(presetn) |-> pv == 4'hc && !rs && !ri; endproperty
    a_rst: assert property (p_rst) else $error("rst");
    property p_ro; wr && paddr == 12'h004 |=> $stable(pv); endproperty
    a_ro: assert property (p_ro) else $error("ro");
    property p_md; wr && paddr == 12'h008 |=> {ri, rs} == $past(pwdata[1:0]); endproperty
    a_md: assert property (p_md) else $error("md");
    property p_by; !(rs & pv[2]) && !(ri & pv[3]); endproperty
    a_by: assert property (p_by) else $error("by");
endmodule
bind sensor_drive_gpio_port gpio_port_props gpio_port_props_inst (.*);
`default_nettype wire

//--- tb/sensor_lines.sv
`timescale 1ns/1ps
`default_nettype none
// released pins show the sensor level, never a stale drive
module sensor_lines (
    input wire logic port_pin_zero_out, port_pin_zero_oe, port_pin_one_out, port_pin_one_oe, ext0, ext1,
    output logic     port_pin_zero_in, port_pin_one_in
);
    assign port_pin_zero_in = port_pin_zero_oe ? port_pin_zero_out : ext0;
    assign port_pin_one_in = port_pin_one_oe ? port_pin_one_out : ext1;
endmodule
`default_nettype wire

//--- tb/sensor_drive_gpio_port_test.sv
`timescale 1ns/1ps
`default_nettype none
module sensor_drive_gpio_port_test;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ext0 = 1, ext1 = 1;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, r;
    logic        e;
    wire logic   pready, pslverr, port_pin_zero_in, port_pin_zero_out, port_pin_zero_oe, port_pin_one_in;
    wire logic   port_pin_one_out, port_pin_one_oe, reference_monitor_out_select, external_reference_in_select;
    wire logic [31:0] prdata;
    int err_total = 0, compares = 0;
    sensor_drive_gpio_port sensor_drive_gpio_port_inst (.*);
    sensor_lines sensor_lines_inst (.*);
    initial forever #5 pclk = ~pclk;
    task tally_and_finish;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin err_total++; $display("[FAIL] %0t seen %h exp %h", $time, s, e); end
    endtask
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk) penable <= 1;
        repeat (20) begin @(posedge pclk); if (pready === 1'b1) break; end
        if (pready !== 1'b1) begin err_total++; tally_and_finish; end
        r = prdata;
        e = pslverr;
        psel <= 0; penable <= 0;
        // pin levels reach the input register 4 edges late
        repeat (5) @(posedge pclk);
    endtask
    task t_basic;
        xfer(0, 12'h000, 0); chk(r, 32'h30);
        xfer(0, 12'h004, 0); chk(r, 32'h0);
        xfer(1, 12'h000, 32'h12); xfer(0, 12'h004, 0); chk(r, 32'h3);
        xfer(1, 12'h004, 32'hff); xfer(0, 12'h000, 0); chk(r, 32'h12);
        xfer(0, 12'h00c, 0); chk(r, 32'h0); chk({31'h0, e}, 32'h1);
        xfer(0, 12'h008, 0); chk({31'h0, e}, 32'h0);
    endtask
    task t_ext;
        xfer(1, 12'h000, 0); ext0 <= 0; ext1 <= 1; repeat (5) @(posedge pclk);
        xfer(0, 12'h004, 0); chk(r, 32'h2);
        xfer(1, 12'h000, 32'h36); xfer(0, 12'h004, 0); chk(r, 32'h3);
    endtask
    task t_reset;
        xfer(1, 12'h008, 32'h3); presetn <= 0; repeat (2) @(posedge pclk); presetn <= 1;
        xfer(0, 12'h000, 0); chk(r, 32'h30);
        xfer(0, 12'h008, 0); chk(r, 32'h0);
    endtask
    task t_mode;
        xfer(1, 12'h000, 32'h30); xfer(1, 12'h008, 32'h3); xfer(0, 12'h004, 0); chk(r, 32'h3);
        chk({30'h0, external_reference_in_select, reference_monitor_out_select}, 32'h3);
        xfer(1, 12'h008, 0); xfer(0, 12'h004, 0); chk(r, 32'h0);
        chk({30'h0, external_reference_in_select, reference_monitor_out_select}, 32'h0);
    endtask
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1;
        t_basic;
        t_mode;
        t_ext;
        t_reset;
        tally_and_finish;
    end
endmodule
`default_nettype wire
